// File: rtl/stack_light_pkg.sv
package stack_light_pkg;
	localparam int CLK_NS        = 10;
	localparam int LED_COUNT     = 20;
	localparam int SEG_LEDS      = 4;
	localparam int SEG_COUNT     = 5;
	localparam int PD_W          = 56;
	localparam int I2C_QTR_NS    = 2500;
	localparam int I2C_QTR_CYC   = (I2C_QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_US       = 20;
	localparam int CONV_CYC      = (CONV_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int BLINK_TICK_MS = 10;
	localparam int RUN_STEP_MS   = 100;
	localparam int DEMO_DWELL_MS = 1000;
	localparam int TEMP_MUL      = 165;
	localparam int HUM_MUL       = 100;
	localparam int RAW_SHIFT     = 16;
	localparam int TEMP_OFS      = 40;
	localparam int BAR_SCALE     = 20;
	localparam logic [6:0]  SENSOR_ADDR = 7'h40;
	localparam logic [7:0]  CFG_PTR     = 8'h02;
	localparam logic [15:0] CFG_VALUE   = 16'h1000;
	localparam logic [7:0]  MEAS_PTR    = 8'h00;
	localparam logic [15:0] TEMP_MIN_RST  = 16'h000f;
	localparam logic [15:0] TEMP_MAX_RST  = 16'h001e;
	localparam logic [15:0] LEVEL_MIN_RST = 16'h0000;
	localparam logic [15:0] LEVEL_MAX_RST = 16'h0064;
	localparam logic [6:0]  BC_MAX      = 7'h7f;
	localparam logic [6:0]  DEFAULT_BC  = 7'h10;
	localparam logic [15:0] DEMO_PAR    = 16'h0514;
	localparam logic [7:0]  DEMO_SEG    = 8'h02;
	localparam logic [23:0] DEMO_RGB    = 24'hffffff;
	localparam logic [23:0] TEMP_RGB    = 24'hff2000;
	localparam logic [23:0] LEVEL_RGB   = 24'h0040ff;
	localparam logic [4:0][23:0] SEG_RGB = {24'hffffff, 24'h0000ff,
		24'h00ff00, 24'hffbf00, 24'hff0000};
	localparam int MB_ON  = 0;
	localparam int MB_PAT = 1;
	localparam int MB_OP  = 4;
	typedef enum logic [1:0] {MODE_DEMO = 2'b00, MODE_TEMP = 2'b01,
		MODE_HUM = 2'b10, MODE_HOST = 2'b11} mode_e;
	typedef enum logic [2:0] {PAT_ALL_ON = 3'b000, PAT_BLINK = 3'b001,
		PAT_SEG = 3'b010, PAT_TEMP = 3'b011, PAT_RUN = 3'b100,
		PAT_LEVEL = 3'b101} pat_e;
	typedef enum logic [1:0] {OPN_NORMAL = 2'b00, OPN_CFG_TEMP = 2'b01,
		OPN_CFG_LEVEL = 2'b10} opn_e;
	typedef enum logic [2:0] {OP_START = 3'b000, OP_WR = 3'b001,
		OP_RDA = 3'b010, OP_RDN = 3'b011, OP_STOP = 3'b100,
		OP_WAIT = 3'b101, OP_CALC = 3'b110} i2c_op_e;
endpackage

// File: rtl/stack_light_command_controller.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - reset enters demo, cycling all patterns
// RULE2 - first press: temperature mode, indicator on
// RULE3 - second press: humidity mode, indicator on
// RULE4 - third press: host mode, both indicators
// RULE5 - brightness is seven bits, capped
// RULE6 - red, green, blue independent eight-bit values
// RULE7 - blink state toggles every parameter[15:8] + 1 timer ticks
// RULE8 - segment pattern lights one fixed-colour segment
// RULE9 - run light advances its own position
// RULE10 - temperature and level shown as bars
// RULE11 - sensor addressed at seven-bit 0x40
// RULE12 - configure: pointer 0x02, value 0x1000
// RULE13 - trigger pointer 0x0, wait, read
// RULE14 - temperature: times 165, shift 16, minus 40
// RULE15 - lit count: 20*(v-min)/(max-min)
// RULE16 - humidity: times 100, shift 16
// RULE17 - temperature range resets to 15..30
// RULE18 - level range resets to 0..100
// RULE19 - capture new process data on change
// RULE20 - split into mode, parameter, configuration
// RULE21 - mode bit0 on/off, bits 3:1 pattern
// RULE22 - bits 5:4 normal or range configure
// RULE23 - configured range replaces stored bounds
module stack_light_command_controller
	import stack_light_pkg::*;
#(
	parameter int BLINK_TICK_CYC = BLINK_TICK_MS * 1000000 / CLK_NS,
	parameter int RUN_STEP_CYC   = RUN_STEP_MS * 1000000 / CLK_NS,
	parameter int DEMO_DWELL_CYC = DEMO_DWELL_MS * 1000000 / CLK_NS,
	parameter int QTR_CYC        = I2C_QTR_CYC
) (
	input  wire  logic              MCLK,
	input  wire  logic              RSTN,
	input  wire  logic              LINK_CLK,
	input  wire  logic              LINK_PD_VALID,
	input  wire  logic [PD_W-1:0]   LINK_PD_DATA,
	input  wire  logic              MODE_SELECT_BUTTON,
	input  wire  logic              SENSOR_SCL_IN,
	input  wire  logic              SENSOR_SDA_IN,
	output logic                    SENSOR_SCL_OUT,
	output logic                    SENSOR_SCL_OE,
	output logic                    SENSOR_SDA_OUT,
	output logic                    SENSOR_SDA_OE,
	output logic                    TEMPERATURE_MODE_INDICATOR,
	output logic                    HUMIDITY_MODE_INDICATOR,
	output logic [LED_COUNT-1:0]    LED_ON_MASK,
	output logic [7:0]              LED_RED,
	output logic [7:0]              LED_GREEN,
	output logic [7:0]              LED_BLUE,
	output logic [6:0]              GLOBAL_BRIGHTNESS
);

	// ==========================================================
	// link domain: hold process data, toggle on change
	typedef struct packed {
		logic            rs1;
		logic            rs2;
		logic [PD_W-1:0] held;
		logic            tog;
	} lk_s;

	lk_s lk_reg, lk_next;

	always_comb begin
		lk_next = lk_reg;
		lk_next.rs1 = RSTN;
		lk_next.rs2 = lk_reg.rs1;
		if (!lk_reg.rs2) begin
			lk_next.held = '0;
			lk_next.tog = 1'b0;
		end else if (LINK_PD_VALID && LINK_PD_DATA != lk_reg.held) begin
			lk_next.held = LINK_PD_DATA; // see RULE19
			lk_next.tog = ~lk_reg.tog;
		end
	end

	always_ff @(posedge LINK_CLK) begin
		lk_reg <= lk_next;
	end

	// ==========================================================
	// system domain state
	typedef struct packed {
		mode_e                 mode;
		logic                  btn_s1, btn_s2, btn_d;
		logic                  tog_s1, tog_s2, tog_d;
		logic                  scl_s1, scl_s2, sda_s1, sda_s2;
		logic                  h_on;
		pat_e                  h_pat;
		logic [15:0]           h_par;
		logic [23:0]           h_rgb;
		logic [6:0]            h_bc;
		logic [15:0]           t_min, t_max, l_min, l_max;
		logic [4:0]            step;
		logic [1:0]            ph;
		logic [7:0]            qcnt;
		logic [3:0]            bitn;
		logic [7:0]            sh;
		logic [31:0]           rx;
		logic [10:0]           wcnt;
		logic [15:0]           s_temp, s_hum;
		logic [31:0]           bl_cnt;
		logic [7:0]            ivl_cnt;
		logic                  bl_state;
		logic [31:0]           run_cnt;
		logic [4:0]            run_pos;
		logic [31:0]           dm_cnt;
		logic [2:0]            dm_idx;
		logic                  scl_oe, sda_oe, ind_t, ind_h;
		logic [LED_COUNT-1:0]  mask;
		logic [23:0]           rgb;
		logic [6:0]            bc;
	} st_s;

	st_s st_reg, st_next;

	function automatic logic [10:0] step_op(input logic [4:0] s);
		case (s)
			5'h00, 5'h06, 5'h0b: step_op = {OP_START, 8'h00};
			5'h01, 5'h07: step_op = {OP_WR, SENSOR_ADDR, 1'b0}; // see RULE11
			5'h02: step_op = {OP_WR, CFG_PTR};
			5'h03: step_op = {OP_WR, CFG_VALUE[15:8]};
			5'h04: step_op = {OP_WR, CFG_VALUE[7:0]};
			5'h08: step_op = {OP_WR, MEAS_PTR};
			5'h05, 5'h09, 5'h11: step_op = {OP_STOP, 8'h00};
			5'h0a: step_op = {OP_WAIT, 8'h00};
			5'h0c: step_op = {OP_WR, SENSOR_ADDR, 1'b1};
			5'h0d, 5'h0e, 5'h0f: step_op = {OP_RDA, 8'h00};
			5'h10: step_op = {OP_RDN, 8'h00};
			default: step_op = {OP_CALC, 8'h00};
		endcase
	endfunction

	function automatic logic [4:0] bar_of(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		logic signed [31:0] num;
		logic signed [31:0] den;
		logic signed [31:0] q;
		num = BAR_SCALE * ($signed(32'($signed(v))) -
			$signed(32'($signed(lo))));
		den = $signed(32'($signed(hi))) - $signed(32'($signed(lo)));
		q = (den > 0 && num > 0) ? num / den : 32'sh0;
		bar_of = (q > BAR_SCALE) ? 5'(BAR_SCALE) : q[4:0];
	endfunction

	function automatic logic [LED_COUNT-1:0] low_mask(input logic [7:0] n);
		for (int i = 0; i < LED_COUNT; i++) begin
			low_mask[i] = (8'(i) < n);
		end
	endfunction

	logic press, new_pd, qtick, stall, scl_lvl, sda_lvl;
	logic sensing, run_tick, bl_tick;
	logic [7:0] pd_mb;
	i2c_op_e op;
	logic [10:0] cur_op, nxt_op;
	logic [31:0] prod;
	pat_e e_pat;
	logic e_on;
	logic [15:0] e_par;
	logic [7:0] e_seg;
	logic [23:0] e_rgb;
	logic [6:0] e_bc;
	logic [15:0] e_val, e_lo, e_hi;
	logic [4:0] bar;
	logic [7:0] run_len;

	always_comb begin
		st_next = st_reg;
		// ==========================================================
		// synchronisers and mode button
		st_next.btn_s1 = MODE_SELECT_BUTTON;
		st_next.btn_s2 = st_reg.btn_s1;
		st_next.btn_d = st_reg.btn_s2;
		st_next.tog_s1 = lk_reg.tog;
		st_next.tog_s2 = st_reg.tog_s1;
		st_next.tog_d = st_reg.tog_s2;
		st_next.scl_s1 = SENSOR_SCL_IN;
		st_next.scl_s2 = st_reg.scl_s1;
		st_next.sda_s1 = SENSOR_SDA_IN;
		st_next.sda_s2 = st_reg.sda_s1;
		press = st_reg.btn_s2 & ~st_reg.btn_d;
		new_pd = st_reg.tog_s2 ^ st_reg.tog_d;
		if (press) begin
			case (st_reg.mode)
				MODE_DEMO: st_next.mode = MODE_TEMP; // see RULE2
				MODE_TEMP: st_next.mode = MODE_HUM; // see RULE3
				MODE_HUM: st_next.mode = MODE_HOST; // see RULE4
				default: st_next.mode = MODE_DEMO;
			endcase
		end
		st_next.ind_t = st_next.mode == MODE_TEMP || st_next.mode == MODE_HOST;
		st_next.ind_h = st_next.mode == MODE_HUM || st_next.mode == MODE_HOST;

		// ==========================================================
		// host process data decode
		pd_mb = lk_reg.held[55:48]; // see RULE20
		if (new_pd && st_reg.mode == MODE_HOST) begin
			case (opn_e'(pd_mb[MB_OP+:2])) // see RULE22
				OPN_NORMAL: begin
					st_next.h_on = pd_mb[MB_ON]; // see RULE21
					st_next.h_pat = pat_e'(pd_mb[MB_PAT+:3]);
					st_next.h_par = lk_reg.held[47:32];
					st_next.h_rgb = lk_reg.held[31:8]; // see RULE6
					st_next.h_bc = lk_reg.held[7] ? BC_MAX
						: lk_reg.held[6:0]; // see RULE5
				end
				OPN_CFG_TEMP: begin
					st_next.t_max = lk_reg.held[31:16]; // see RULE23
					st_next.t_min = lk_reg.held[15:0];
				end
				OPN_CFG_LEVEL: begin
					st_next.l_max = lk_reg.held[31:16]; // see RULE23
					st_next.l_min = lk_reg.held[15:0];
				end
				default: ;
			endcase
		end

		// ==========================================================
		// sensor bus sequencer
		sensing = st_reg.mode == MODE_TEMP || st_reg.mode == MODE_HUM;
		cur_op = step_op(st_reg.step); // see RULE12
		nxt_op = step_op(st_reg.step + 5'h01);
		op = i2c_op_e'(cur_op[10:8]);
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		prod = '0;
		case (op)
			OP_START: begin
				scl_lvl = st_reg.ph != 2'd2;
				sda_lvl = st_reg.ph == 2'd0;
			end
			OP_STOP: begin
				scl_lvl = st_reg.ph != 2'd0;
				sda_lvl = st_reg.ph == 2'd2;
			end
			OP_WR: begin
				scl_lvl = st_reg.ph == 2'd1 || st_reg.ph == 2'd2;
				sda_lvl = st_reg.bitn[3] | st_reg.sh[7];
			end
			OP_RDA, OP_RDN: begin
				scl_lvl = st_reg.ph == 2'd1 || st_reg.ph == 2'd2;
				sda_lvl = ~st_reg.bitn[3] | (op == OP_RDN);
			end
			default: ;
		endcase
		stall = (scl_lvl && !st_reg.scl_s2 && st_reg.ph != 2'd0) ||
			(st_reg.step == 5'h06 && !sensing);
		qtick = st_reg.qcnt == 8'(QTR_CYC - 1) && !stall;
		st_next.scl_oe = ~scl_lvl;
		st_next.sda_oe = ~sda_lvl;
		if (!stall) begin
			st_next.qcnt = qtick ? 8'h00 : st_reg.qcnt + 8'h01;
		end
		if (op == OP_WAIT) begin
			st_next.qcnt = 8'h00;
			st_next.wcnt = st_reg.wcnt + 11'h001;
			if (st_reg.wcnt == 11'(CONV_CYC - 1)) begin // see RULE13
				st_next.wcnt = 11'h000;
				st_next.step = st_reg.step + 5'h01;
			end
		end else if (op == OP_CALC) begin
			prod = 32'(st_reg.rx[31:16]) * TEMP_MUL; // see RULE14
			st_next.s_temp = 16'(prod >> RAW_SHIFT) - 16'(TEMP_OFS);
			prod = 32'(st_reg.rx[15:0]) * HUM_MUL; // see RULE16
			st_next.s_hum = 16'(prod >> RAW_SHIFT);
			st_next.step = 5'h06;
			st_next.sh = 8'h00;
		end else if (qtick) begin
			st_next.ph = st_reg.ph + 2'd1;
			if ((op == OP_START || op == OP_STOP) && st_reg.ph == 2'd2) begin
				st_next.ph = 2'd0;
				st_next.step = st_reg.step + 5'h01;
				st_next.sh = nxt_op[7:0];
			end
			// only read data bits sample, so the acknowledge bit keeps the received byte
			if ((op == OP_RDA || op == OP_RDN) && st_reg.ph == 2'd2 &&
				!st_reg.bitn[3]) begin
				st_next.sh = {st_reg.sh[6:0], st_reg.sda_s2};
			end
			if ((op == OP_WR || op == OP_RDA || op == OP_RDN) &&
				st_reg.ph == 2'd3) begin
				st_next.bitn = st_reg.bitn + 4'h1;
				if (op == OP_WR) begin
					st_next.sh = {st_reg.sh[6:0], 1'b1};
				end
				if (st_reg.bitn == 4'h8) begin
					st_next.bitn = 4'h0;
					st_next.step = st_reg.step + 5'h01;
					st_next.sh = nxt_op[7:0];
					if (op != OP_WR) begin
						st_next.rx = {st_reg.rx[23:0], st_reg.sh};
					end
				end
			end
		end

		// ==========================================================
		// pattern timers
		bl_tick = st_reg.bl_cnt == 32'(BLINK_TICK_CYC - 1);
		st_next.bl_cnt = bl_tick ? 32'h0 : st_reg.bl_cnt + 32'h1;
		run_tick = st_reg.run_cnt == 32'(RUN_STEP_CYC - 1);
		st_next.run_cnt = run_tick ? 32'h0 : st_reg.run_cnt + 32'h1;
		st_next.dm_cnt = st_reg.dm_cnt + 32'h1;
		if (st_reg.dm_cnt == 32'(DEMO_DWELL_CYC - 1)) begin // see RULE1
			st_next.dm_cnt = 32'h0;
			st_next.dm_idx = (st_reg.dm_idx == PAT_LEVEL) ? 3'h0
				: st_reg.dm_idx + 3'h1;
		end

		// ==========================================================
		// effective settings per operating mode
		e_pat = pat_e'(st_reg.dm_idx);
		e_on = 1'b1;
		e_par = DEMO_PAR;
		e_seg = DEMO_SEG;
		e_rgb = DEMO_RGB;
		e_bc = DEFAULT_BC;
		e_val = (e_pat == PAT_TEMP) ? st_reg.s_temp : st_reg.s_hum;
		case (st_reg.mode)
			MODE_TEMP: begin
				e_pat = PAT_TEMP;
				e_val = st_reg.s_temp;
			end
			MODE_HUM: begin
				e_pat = PAT_LEVEL;
				e_val = st_reg.s_hum;
			end
			MODE_HOST: begin
				e_pat = st_reg.h_pat;
				e_on = st_reg.h_on;
				e_par = st_reg.h_par;
				e_seg = st_reg.h_par[7:0];
				e_rgb = st_reg.h_rgb;
				e_bc = st_reg.h_bc;
				e_val = st_reg.h_par;
			end
			default: ;
		endcase
		e_lo = (e_pat == PAT_TEMP) ? st_reg.t_min : st_reg.l_min;
		e_hi = (e_pat == PAT_TEMP) ? st_reg.t_max : st_reg.l_max;
		bar = bar_of(e_val, e_lo, e_hi); // see RULE15
		run_len = (e_par[7:0] == 8'h00) ? 8'h01
			: (e_par[7:0] > 8'(LED_COUNT)) ? 8'(LED_COUNT) : e_par[7:0];
		if (bl_tick && e_pat == PAT_BLINK) begin
			st_next.ivl_cnt = st_reg.ivl_cnt + 8'h01;
			if (st_reg.ivl_cnt >= e_par[15:8]) begin
				st_next.ivl_cnt = 8'h00;
				st_next.bl_state = ~st_reg.bl_state; // see RULE7
			end
		end
		if (run_tick) begin
			st_next.run_pos = (8'(st_reg.run_pos) + 8'h01 >= run_len) ? 5'h00
				: st_reg.run_pos + 5'h01; // see RULE9
		end

		// ==========================================================
		// pattern rendering
		st_next.rgb = e_rgb;
		st_next.bc = e_bc;
		case (e_pat)
			PAT_ALL_ON: st_next.mask = low_mask(e_par[7:0]);
			PAT_BLINK: st_next.mask = st_reg.bl_state ? low_mask(e_par[7:0])
				: '0; // see RULE7
			PAT_SEG: begin
				st_next.mask = (e_seg < 8'(SEG_COUNT)) ?
					LED_COUNT'(4'hf) << (SEG_LEDS * e_seg) : '0; // see RULE8
				st_next.rgb = (e_seg < 8'(SEG_COUNT)) ?
					SEG_RGB[e_seg[2:0]] : '0;
			end
			PAT_TEMP: begin
				st_next.mask = low_mask(8'(bar)); // see RULE10
				st_next.rgb = TEMP_RGB;
			end
			PAT_RUN: st_next.mask = LED_COUNT'(1) << st_reg.run_pos;
			PAT_LEVEL: begin
				st_next.mask = low_mask(8'(bar)); // see RULE10
				st_next.rgb = LEVEL_RGB;
			end
			default: st_next.mask = '0;
		endcase
		if (!e_on) begin
			st_next.mask = '0; // see RULE21
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			st_reg <= '0;
			st_reg.t_min <= TEMP_MIN_RST; // see RULE17
			st_reg.t_max <= TEMP_MAX_RST;
			st_reg.l_min <= LEVEL_MIN_RST; // see RULE18
			st_reg.l_max <= LEVEL_MAX_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign SENSOR_SCL_OUT = 1'b0 & st_reg.scl_oe;
	assign SENSOR_SDA_OUT = 1'b0 & st_reg.sda_oe;
	assign SENSOR_SCL_OE = st_reg.scl_oe;
	assign SENSOR_SDA_OE = st_reg.sda_oe;
	assign TEMPERATURE_MODE_INDICATOR = st_reg.ind_t;
	assign HUMIDITY_MODE_INDICATOR = st_reg.ind_h;
	assign LED_ON_MASK = st_reg.mask;
	assign {LED_RED, LED_GREEN, LED_BLUE} = st_reg.rgb;
	assign GLOBAL_BRIGHTNESS = st_reg.bc;

	// ==========================================================
	// checks
	sequence s_press;
		st_reg.btn_s2 && !st_reg.btn_d;
	endsequence
	sequence s_host_pd(logic [1:0] o);
		new_pd && st_reg.mode == MODE_HOST && pd_mb[MB_OP+:2] == o;
	endsequence
	sequence s_host_on(pat_e p);
		st_reg.mode == MODE_HOST && st_reg.h_on && st_reg.h_pat == p;
	endsequence

	AST_RESET_DEMO: assert property (@(posedge MCLK) // see RULE1
		$rose(RSTN) |-> st_reg.mode == MODE_DEMO && !LED_ON_MASK[0])
		else $error("not in demo after reset");
	AST_TO_TEMP: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE2
		s_press ##0 st_reg.mode == MODE_DEMO |=> st_reg.mode == MODE_TEMP
		&& TEMPERATURE_MODE_INDICATOR && !HUMIDITY_MODE_INDICATOR)
		else $error("first press did not enter temperature mode");
	AST_TO_HUM: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE3
		s_press ##0 st_reg.mode == MODE_TEMP |=> st_reg.mode == MODE_HUM
		&& HUMIDITY_MODE_INDICATOR && !TEMPERATURE_MODE_INDICATOR)
		else $error("second press did not enter humidity mode");
	AST_TO_HOST: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE4
		s_press ##0 st_reg.mode == MODE_HUM |=> st_reg.mode == MODE_HOST
		&& HUMIDITY_MODE_INDICATOR && TEMPERATURE_MODE_INDICATOR)
		else $error("third press did not enter host mode");
	AST_ALLON_BC: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE5
		s_host_on(PAT_ALL_ON) |=> GLOBAL_BRIGHTNESS == $past(st_reg.h_bc))
		else $error("brightness not applied");
	AST_ALLON_RGB: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE6
		s_host_on(PAT_ALL_ON) |=>
		{LED_RED, LED_GREEN, LED_BLUE} == $past(st_reg.h_rgb))
		else $error("colour not applied");
	AST_BLINK_OFF: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE7
		s_host_on(PAT_BLINK) ##0 !st_reg.bl_state |=> LED_ON_MASK == '0)
		else $error("blink off phase lit");
	AST_ADDR: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE11
		st_reg.step == 5'h07 && st_reg.bitn == 4'h0 && st_reg.ph == 2'd0
		|-> st_reg.sh == {SENSOR_ADDR, 1'b0})
		else $error("wrong sensor address");
	AST_RANGE_RST: assert property (@(posedge MCLK) // see RULE17
		$rose(RSTN) |-> st_reg.t_min == TEMP_MIN_RST
		&& st_reg.t_max == TEMP_MAX_RST && st_reg.l_max == LEVEL_MAX_RST)
		else $error("range reset wrong");
	AST_PARAM: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE20
		s_host_pd(OPN_NORMAL) |=> st_reg.h_par == $past(lk_reg.held[47:32]))
		else $error("parameter word not captured");
	AST_CFG_T: assert property (@(posedge MCLK) disable iff (!RSTN) // see RULE23
		s_host_pd(OPN_CFG_TEMP) |=> st_reg.t_max == $past(lk_reg.held[31:16])
		&& st_reg.h_par == $past(st_reg.h_par))
		else $error("temperature range not stored");
endmodule

// File: sim/sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic [31:0] raw_data,
	output logic             sda_oe,
	output logic [55:0]      rx_log,
	output int               reads
);
	int         bit_n = 0;
	int         byte_n = 0;
	logic       rd = 0;
	logic       go_rd = 0;
	logic [7:0] sh = '0;
	initial begin
		sda_oe = 0;
		rx_log = '0;
		reads = 0;
	end
	// start condition restarts byte framing
	always @(negedge sda) if (scl === 1'b1) begin
		bit_n = -1;
		rd = 0;
		go_rd = 0;
		byte_n = 0;
	end
	always @(posedge scl) sh = {sh[6:0], sda};
	always @(negedge scl) begin
		bit_n = bit_n + 1;
		if (bit_n == 8) begin
			sda_oe = !rd;
			if (!rd) begin
				go_rd = (sh == 8'h81);
				rx_log = {rx_log[47:0], sh};
			end
		end else if (bit_n == 9) begin
			bit_n = 0;
			if (rd) begin
				byte_n++;
				if (byte_n == 4) reads++;
			end
			rd = rd | go_rd;
		end
		// read data goes out msb first, released once four bytes are sent
		if (rd && bit_n < 8 && byte_n < 4)
			sda_oe = !raw_data[31 - byte_n * 8 - bit_n];
		else if (bit_n != 8)
			sda_oe = 0;
	end
endmodule

// File: sim/test_stack_light_command_controller.sv
`timescale 1ns/1ps
module test_stack_light_command_controller
	import stack_light_pkg::*;
	;
	logic        mclk = 0;
	logic        rstn = 0;
	logic        link_clk = 0;
	logic        pd_valid = 0;
	logic [55:0] pd_data = '0;
	logic        button = 0;
	logic [31:0] raw = '0;
	logic        scl_out, scl_oe, sda_out, sda_oe, model_oe, t_ind, h_ind;
	logic [19:0] mask;
	logic [7:0]  red, green, blue;
	logic [6:0]  bright;
	logic [55:0] rx_log;
	int          reads;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	wire         scl_w = scl_oe ? scl_out : 1'b1;
	wire         sda_w = (sda_oe ? sda_out : 1'b1) & !model_oe;
	always #5 mclk = ~mclk;
	always #16 link_clk = ~link_clk;
	stack_light_command_controller #(
		.BLINK_TICK_CYC (20),
		.RUN_STEP_CYC   (20),
		.DEMO_DWELL_CYC (50),
		.QTR_CYC        (25)
	) stack_light_command_controller_inst (
		.MCLK(mclk), .RSTN(rstn), .LINK_CLK(link_clk),
		.LINK_PD_VALID(pd_valid), .LINK_PD_DATA(pd_data),
		.MODE_SELECT_BUTTON(button),
		.SENSOR_SCL_IN(scl_w), .SENSOR_SDA_IN(sda_w),
		.SENSOR_SCL_OUT(scl_out), .SENSOR_SCL_OE(scl_oe),
		.SENSOR_SDA_OUT(sda_out), .SENSOR_SDA_OE(sda_oe),
		.TEMPERATURE_MODE_INDICATOR(t_ind), .HUMIDITY_MODE_INDICATOR(h_ind),
		.LED_ON_MASK(mask), .LED_RED(red), .LED_GREEN(green),
		.LED_BLUE(blue), .GLOBAL_BRIGHTNESS(bright)
	);
	sensor_model sensor_model_inst (
		.scl(scl_w), .sda(sda_w), .raw_data(raw), .sda_oe(model_oe),
		.rx_log(rx_log), .reads(reads)
	);
	// ======================================================
	// helpers
	task automatic check(input logic [55:0] seen, input logic [55:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic press();
		button = 1;
		ticks(6);
		button = 0;
		ticks(6);
	endtask
	task automatic send(input logic [55:0] w);
		@(negedge link_clk);
		pd_valid = 1;
		pd_data = w;
		repeat (4) @(negedge link_clk);
		ticks(10);
	endtask
	task automatic wait_reads(input int n);
		for (int i = 0; i < 20000 && reads < n; i++) ticks(1);
		ticks(300);
	endtask
	function automatic int bar(input int v, input int lo, input int hi);
		int n;
		n = (hi <= lo || v <= lo) ? 0 : BAR_SCALE * (v - lo) / (hi - lo);
		return n > LED_COUNT ? LED_COUNT : n;
	endfunction
	function automatic logic [31:0] fill(input int n);
		return (32'h1 << n) - 32'h1;
	endfunction
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			num_errors++;
			results();
		end
	end
	// ======================================================
	// stimulus
	initial begin
		int          n, t, h, moves;
		logic [31:0] c;
		logic [19:0] v;
		logic        z, f, ok;
		void'($urandom(38346));
		raw = {16'h5500 + 16'($urandom_range(0, 16'h1c00)), 16'($urandom)};
		ticks(20);
		rstn = 1;
		ticks(2);
		check({t_ind, h_ind}, 2'b00);
		n = 0;
		v = mask;
		repeat (400) begin
			ticks(1);
			if (mask !== v) n++;
			v = mask;
		end
		check(n > 3, 1);
		press();
		check({t_ind, h_ind}, 2'b10);
		wait_reads(1);
		check(rx_log, 56'h80021000800081);
		check({scl_out, sda_out}, 2'b00);
		t = ((int'(raw[31:16]) * TEMP_MUL) >>> RAW_SHIFT) - TEMP_OFS;
		check(mask, fill(bar(t, 15, 30)));
		check({red, green, blue, bright}, {TEMP_RGB, DEFAULT_BC});
		press();
		check({t_ind, h_ind}, 2'b01);
		wait_reads(2);
		h = (int'(raw[15:0]) * HUM_MUL) >>> RAW_SHIFT;
		check(mask, fill(bar(h, 0, 100)));
		check({red, green, blue}, LEVEL_RGB);
		press();
		check({t_ind, h_ind}, 2'b11);
		repeat (4) begin
			n = $urandom_range(1, 20);
			c = $urandom;
			send({8'h01, 8'h00, n[7:0], c});
			check(mask, fill(n));
			check({red, green, blue}, c[31:8]);
			check(bright, c[7] ? 7'h7f : c[6:0]);
		end
		send({8'h31, 8'h00, 8'h05, 32'h0});
		check(mask, fill(n));
		send({8'h00, 8'h00, 8'h14, 32'hffffff01});
		check(mask, 0);
		for (int s = 0; s < 6; s++) begin
			send({8'h05, 8'h00, 8'(s), 32'h0});
			check(mask, s < 5 ? 32'hf << (4 * s) : 32'h0);
			if (s < 5) check({red, green, blue}, SEG_RGB[s]);
		end
		send({8'h10, 16'h0, 16'd40, 16'd20});
		send({8'h07, 16'd30, 32'h01});
		check(mask, fill(bar(30, 20, 40)));
		send({8'h20, 16'h0, 16'd200, 16'd0});
		send({8'h0b, 16'd50, 32'h0});
		check(mask, fill(bar(50, 0, 200)));
		check({red, green, blue}, LEVEL_RGB);
		send({8'h03, 8'h00, 8'h14, 32'h00ff0001});
		z = 0;
		f = 0;
		repeat (200) begin
			ticks(1);
			z |= (mask === 20'h0);
			f |= (mask === 20'hfffff);
		end
		check(z && f, 1);
		send({8'h09, 8'h00, 8'h04, 32'hff000001});
		ticks(25);
		ok = 1;
		moves = 0;
		v = mask;
		repeat (300) begin
			ticks(1);
			ok &= $onehot(mask) && (mask < 20'h10);
			if (mask !== v) moves++;
			v = mask;
		end
		check(ok && moves > 4, 1);
		press();
		check({t_ind, h_ind}, 2'b00);
		results();
	end
endmodule
